/* cfq_cpu_front_end.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - memory controller holds bus controller, four-byte prefetch queue, fetch address counter.
// - queue request beats datapath request when both want the bus.
// - every queue fetch uses the fetch address counter as its address.
// - jump, call, return or interrupt reloads counter, flushes queue, refetches.
// - reload plus first byte of new stream takes four state times.
// - one bus controller serves internal program memory and external bus.
// - register space reads bypass memory controller; all else goes through it.
// - sixteen-bit data path to memory, eight-bit instruction byte path.
// - queue bytes land in instruction register; microcode sequencer decodes them.
// - seventeen-bit alu, status word, program counter, loop counter, three temporaries.
// - incrementer advances pc on fetches; control flow targets go through alu.
// - lower and upper words shift together as a 32-bit pair.
// - repetitive shift steps are counted in a six-bit loop counter.
// - second operand register may be inverted into alu b input.
// - constants zero, one and two are available inside datapath.
// - bit test mask is one-hot from a three-bit bit select.
// - state time is oscillator divided by two.
// - state clock output pin shows internal state timing.
// - memory controller addresses a unified 64k byte space.
// - 0000-01FF and 1FFE-2080 are flagged special; rest is general storage.
// - datapath works on the upper word as accumulator; register space is reached only by loads.
// - instruction fetches below 0200 always go to external memory.
module cfq_cpu_front_end
    import cfq_pkg::*;
(
    // clock, reset, freeze
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // state timing
    output logic state_clock_output,
    // memory bus
    output logic mem_req_q,
    output cfq_mem_cmd_t mem_cmd_q,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // register space port
    output logic rf_rd_q,
    output logic [8:0] rf_addr_q,
    input wire logic [15:0] rf_rdata,
    // interrupt controller
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    output logic irq_ack_q,
    // visible cpu state
    output logic [7:0] instr_reg_q,
    output logic [15:0] prog_counter_q,
    output logic [15:0] program_status_word_q,
    output logic [15:0] upper_word_q,
    output logic [15:0] lower_word_q,
    output logic [5:0] loop_counter_q
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_OP, S_IMM_LO, S_IMM_HI, S_EXEC, S_SHIFT, S_MEM, S_RF, S_REDIR
    } cfq_seq_t;
    cfq_seq_t seq_q;
    logic phase_q, ce, q_push, q_pop, q_want, dp_want, flush, drop_q, irq_take;
    logic [7:0] q_mem [QUEUE_DEPTH];
    logic [1:0] q_wr_q, q_rd_q;
    logic [2:0] q_cnt_q;
    logic [7:0] q_head, fetch_byte, imm_lo_q, bit_mask;
    logic [15:0] fetch_addr_counter_q, tmp_b_q, alu_a, alu_b, konst;
    logic alu_inv, alu_cin, alu_carry;
    cfq_alufn_t alu_fn;
    logic [16:0] alu_sum, alu_res;
    cfq_opclass_t cls;
    // region flags for any access; fetches never use the register port
    function automatic cfq_mem_cmd_t region(input logic [15:0] addr, input logic fetch);
        cfq_mem_cmd_t c;
        c.addr = addr;
        c.fetch = fetch;
        c.internal = (addr >= ROM_START) && (addr <= ROM_END);
        c.special = (addr <= REG_SPACE_END) ||
            ((addr >= SPECIAL_HI_START) && (addr <= SPECIAL_HI_END));
        return c;
    endfunction

    // ------------------------------------------------------------
    // state timing
    // ------------------------------------------------------------
    // one state is two mclk periods; all cpu state moves on ce
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
        end else if (clk_en) begin
            phase_q <= ~phase_q;
        end
    end

    assign ce = clk_en & phase_q;
    assign state_clock_output = phase_q;

    // ------------------------------------------------------------
    // prefetch queue
    // ------------------------------------------------------------
    assign cls = op_class(instr_reg_q);
    assign irq_take = (seq_q == S_OP) && irq_req;
    assign flush = ce && (seq_q == S_REDIR);
    assign q_head = q_mem[q_rd_q];
    assign fetch_byte = mem_cmd_q.addr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
    assign q_push = ce && mem_req_q && mem_ack && mem_cmd_q.fetch && !drop_q;
    assign q_pop = ce && (q_cnt_q != QCNT_ZERO) &&
        (((seq_q == S_OP) && !irq_req) || (seq_q == S_IMM_LO) || (seq_q == S_IMM_HI));

    // flush wins over a push in the same state: that byte is from the old stream
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q_wr_q <= 2'h0;
            q_rd_q <= 2'h0;
            q_cnt_q <= QCNT_ZERO;
        end else if (ce) begin
            if (flush) begin
                q_wr_q <= 2'h0;
                q_rd_q <= 2'h0;
                q_cnt_q <= QCNT_ZERO;
            end else begin
                if (q_push)
                    q_wr_q <= q_wr_q + QPTR_STEP;
                if (q_pop)
                    q_rd_q <= q_rd_q + QPTR_STEP;
                if (q_push && !q_pop) begin
                    q_cnt_q <= q_cnt_q + QCNT_STEP;
                end else if (q_pop && !q_push) begin
                    q_cnt_q <= q_cnt_q - QCNT_STEP;
                end
            end
        end
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge mclk) begin
        if (q_push && !flush)
            q_mem[q_wr_q] <= fetch_byte;
    end

    // ------------------------------------------------------------
    // bus controller
    // ------------------------------------------------------------
    assign q_want = (q_cnt_q < QUEUE_FULL) && !flush;
    assign dp_want = (seq_q == S_MEM);

    // one access in flight; a fetch caught by a flush is marked and its data dropped
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mem_req_q <= 1'b0;
            mem_cmd_q <= '0;
            drop_q <= 1'b0;
            fetch_addr_counter_q <= CONST_ZERO;
        end else if (ce) begin
            if (mem_req_q && mem_ack) begin
                mem_req_q <= 1'b0;
                drop_q <= 1'b0;
                if (mem_cmd_q.fetch && !drop_q)
                    fetch_addr_counter_q <= fetch_addr_counter_q + ADDR_STEP;
            end else if (!mem_req_q) begin
                if (q_want) begin
                    mem_req_q <= 1'b1;
                    mem_cmd_q <= region(fetch_addr_counter_q, 1'b1);
                end else if (dp_want) begin
                    mem_req_q <= 1'b1;
                    mem_cmd_q <= region(tmp_b_q, 1'b0);
                end
            end
            if (flush) begin
                fetch_addr_counter_q <= alu_res[15:0];
                if (mem_req_q && !mem_ack)
                    drop_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // alu operand selection
    // ------------------------------------------------------------
    assign konst = op_const_two(instr_reg_q) ? CONST_TWO : CONST_ONE;
    assign bit_mask = MASK_SEED << instr_reg_q[2:0];

    always_comb begin
        alu_a = upper_word_q;
        alu_b = tmp_b_q;
        alu_inv = 1'b0;
        alu_cin = 1'b0;
        alu_fn = FN_ADD;
        if (seq_q == S_REDIR) begin
            alu_a = CONST_ZERO;
        end else if (cls == OPC_ALU) begin
            alu_fn = op_fn(instr_reg_q);
            case (alu_fn)
                FN_SUB: begin
                    alu_inv = 1'b1;
                    alu_cin = 1'b1;
                end
                FN_INC: alu_b = konst;
                FN_DEC: begin
                    alu_b = konst;
                    alu_inv = 1'b1;
                    alu_cin = 1'b1;
                end
                FN_NEG: begin
                    alu_a = CONST_ZERO;
                    alu_b = upper_word_q;
                    alu_inv = 1'b1;
                    alu_cin = 1'b1;
                end
                default: alu_inv = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // 17-bit alu: sign extended sum, carry from the unsigned 16-bit sum
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] bx;
        logic [16:0] ucarry;
        bx = alu_inv ? ~alu_b : alu_b;
        ucarry = {1'b0, alu_a} + {1'b0, bx} + {16'h0000, alu_cin};
        alu_sum = {alu_a[SIGN_BIT], alu_a} + {bx[SIGN_BIT], bx} + {16'h0000, alu_cin};
        alu_carry = ucarry[EXT_BIT];
        case (alu_fn)
            FN_AND: alu_res = {1'b0, alu_a & alu_b};
            FN_OR: alu_res = {1'b0, alu_a | alu_b};
            FN_XOR: alu_res = {1'b0, alu_a ^ alu_b};
            default: alu_res = alu_sum;
        endcase
    end

    // ------------------------------------------------------------
    // microcode sequencer
    // ------------------------------------------------------------
    // interrupts are taken only between instructions, at the opcode state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            seq_q <= S_OP;
            instr_reg_q <= 8'h00;
            imm_lo_q <= 8'h00;
            irq_ack_q <= 1'b0;
            rf_rd_q <= 1'b0;
            rf_addr_q <= 9'h000;
        end else if (ce) begin
            irq_ack_q <= 1'b0;
            case (seq_q)
                S_OP: begin
                    if (irq_take) begin
                        irq_ack_q <= 1'b1;
                        seq_q <= S_REDIR;
                    end else if (q_pop) begin
                        instr_reg_q <= q_head;
                        case (op_class(q_head))
                            OPC_RET, OPC_BIT, OPC_NOP: seq_q <= S_EXEC;
                            default: seq_q <= S_IMM_LO;
                        endcase
                    end
                end
                S_IMM_LO: begin
                    if (q_pop) begin
                        imm_lo_q <= q_head;
                        seq_q <= S_IMM_HI;
                    end
                end
                S_IMM_HI: begin
                    if (q_pop)
                        seq_q <= S_EXEC;
                end
                S_EXEC: begin
                    case (cls)
                        OPC_JUMP, OPC_CALL, OPC_RET: seq_q <= S_REDIR;
                        OPC_SHIFT: seq_q <= S_SHIFT;
                        OPC_LOAD: begin
                            if (tmp_b_q <= REG_SPACE_END) begin
                                rf_rd_q <= 1'b1;
                                rf_addr_q <= tmp_b_q[8:0];
                                seq_q <= S_RF;
                            end else begin
                                seq_q <= S_MEM;
                            end
                        end
                        default: seq_q <= S_OP;
                    endcase
                end
                S_SHIFT: begin
                    if (loop_counter_q == LOOP_ZERO)
                        seq_q <= S_OP;
                end
                S_MEM: begin
                    if (mem_req_q && mem_ack && !mem_cmd_q.fetch)
                        seq_q <= S_OP;
                end
                S_RF: begin
                    rf_rd_q <= 1'b0;
                    seq_q <= S_OP;
                end
                default: seq_q <= S_OP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // datapath registers
    // ------------------------------------------------------------
    // pc has its own incrementer; only redirects pass through the alu
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prog_counter_q <= CONST_ZERO;
            program_status_word_q <= CONST_ZERO;
            tmp_b_q <= CONST_ZERO;
            upper_word_q <= CONST_ZERO;
            lower_word_q <= CONST_ZERO;
            loop_counter_q <= LOOP_ZERO;
        end else if (ce) begin
            if (q_pop)
                prog_counter_q <= prog_counter_q + ADDR_STEP;
            if ((seq_q == S_IMM_HI) && q_pop)
                tmp_b_q <= {q_head, imm_lo_q};
            if (irq_take) begin
                lower_word_q <= prog_counter_q;
                tmp_b_q <= irq_vector;
            end
            case (seq_q)
                S_EXEC: begin
                    case (cls)
                        OPC_ALU: begin
                            upper_word_q <= alu_res[15:0];
                            program_status_word_q[PSW_Z] <= (alu_res[15:0] == CONST_ZERO);
                            program_status_word_q[PSW_N] <= alu_res[EXT_BIT];
                            program_status_word_q[PSW_C] <= alu_carry;
                            program_status_word_q[PSW_V] <= alu_res[EXT_BIT] ^ alu_res[SIGN_BIT];
                        end
                        OPC_CALL: lower_word_q <= prog_counter_q;
                        OPC_RET: tmp_b_q <= lower_word_q;
                        OPC_SHIFT: loop_counter_q <= tmp_b_q[5:0];
                        OPC_BIT: begin
                            program_status_word_q[PSW_Z] <= ~|(upper_word_q[7:0] & bit_mask);
                        end
                        default: loop_counter_q <= loop_counter_q;
                    endcase
                end
                S_SHIFT: begin
                    // the pair shifts one bit per state while the loop runs down
                    if (loop_counter_q != LOOP_ZERO) begin
                        loop_counter_q <= loop_counter_q - LOOP_STEP;
                        if (instr_reg_q[0]) begin
                            {upper_word_q, lower_word_q} <= {1'b0, upper_word_q, lower_word_q[15:1]};
                        end else begin
                            {upper_word_q, lower_word_q} <= {upper_word_q[14:0], lower_word_q, 1'b0};
                        end
                    end
                end
                S_MEM: begin
                    if (mem_req_q && mem_ack && !mem_cmd_q.fetch)
                        upper_word_q <= mem_rdata;
                end
                S_RF: upper_word_q <= rf_rdata;
                S_REDIR: begin
                    prog_counter_q <= alu_res[15:0];
                    program_status_word_q[PSW_W] <= 1'b0;
                end
                default: program_status_word_q[PSW_W] <= program_status_word_q[PSW_W];
            endcase
        end
    end
endmodule

/* cfq_front_end_assertions.sv */
`timescale 1ns/1ps
module cfq_front_end_assertions
    import cfq_pkg::*;
(
    // clock and control
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // watched ports
    input wire logic state_clock_output,
    input wire logic mem_req_q,
    input wire cfq_mem_cmd_t mem_cmd_q,
    input wire logic mem_ack,
    input wire logic rf_rd_q,
    input wire logic irq_req,
    input wire logic irq_ack_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic st_edge;
    logic [15:0] a;
    // a state edge is where the divider output was high
    assign st_edge = clk_en && state_clock_output;
    assign a = mem_cmd_q.addr;

    property p_div; clk_en |=> state_clock_output != $past(state_clock_output); endproperty
    a_div: assert property (p_div) else $error("state clock missed a toggle");
    property p_frz; !clk_en |=> $stable(state_clock_output); endproperty
    a_frz: assert property (p_frz) else $error("state clock moved while frozen");
    property p_hold; mem_req_q && !(st_edge && mem_ack) |=> mem_req_q && $stable(mem_cmd_q);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped or changed early");
    property p_gap; $fell(mem_req_q) |-> !mem_req_q ##1 !mem_req_q; endproperty
    a_gap: assert property (p_gap) else $error("request gap shorter than a state");
    property p_ext; mem_req_q && mem_cmd_q.fetch && a <= REG_SPACE_END |-> !mem_cmd_q.internal;
    endproperty
    a_ext: assert property (p_ext) else $error("low fetch not sent outside");
    property p_spc; mem_req_q |-> mem_cmd_q.special ==
        (a <= REG_SPACE_END || (a >= SPECIAL_HI_START && a <= SPECIAL_HI_END)); endproperty
    a_spc: assert property (p_spc) else $error("special flag wrong");
    property p_rom; mem_req_q |-> mem_cmd_q.internal == (a >= ROM_START && a <= ROM_END);
    endproperty
    a_rom: assert property (p_rom) else $error("internal flag wrong");
    property p_byp; mem_req_q && !mem_cmd_q.fetch |-> a > REG_SPACE_END; endproperty
    a_byp: assert property (p_byp) else $error("register access on memory bus");
    property p_rf; $rose(rf_rd_q) && clk_en ##1 clk_en |=> !rf_rd_q; endproperty
    a_rf: assert property (p_rf) else $error("register strobe not one state");
    property p_ack; $rose(irq_ack_q) |-> $past(irq_req) ##1 irq_ack_q ##1 !irq_ack_q;
    endproperty
    a_ack: assert property (p_ack) else $error("interrupt take malformed");
endmodule

bind cfq_cpu_front_end cfq_front_end_assertions u_chk (.mclk, .rst_n, .clk_en,
    .state_clock_output, .mem_req_q, .mem_cmd_q, .mem_ack, .rf_rd_q, .irq_req, .irq_ack_q);

/* cfq_mem_model.sv */
`timescale 1ns/1ps
module cfq_mem_model
    import cfq_pkg::*;
(
    // clock
    input wire logic mclk,
    // memory bus
    input wire logic mem_req_q,
    input wire cfq_mem_cmd_t mem_cmd_q,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    // register space port
    input wire logic rf_rd_q,
    input wire logic [8:0] rf_addr_q,
    output logic [15:0] rf_rdata
);
    logic [7:0] mem [0:65535];
    int wait_cyc = 0;
    int cnt = 0;
    logic [15:0] word;
    // unwritten locations read as erased bytes
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'hA5A5;
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hFF;
    end
    // answer after wait_cyc clocks and hold until the request drops
    always @(posedge mclk) begin
        word = {mem[{mem_cmd_q.addr[15:1], 1'b1}], mem[{mem_cmd_q.addr[15:1], 1'b0}]};
        if (!mem_req_q) begin
            cnt <= 0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata; // released bus alternates each clock between the last word and its inverse
        end else if (cnt >= wait_cyc) begin
            mem_ack <= 1'b1;
            mem_rdata <= word;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // register word derived from its address, inverted outside the strobe
    assign rf_rdata = rf_rd_q ? {rf_addr_q[7:0], ~rf_addr_q[7:0]} : {~rf_addr_q[7:0], rf_addr_q[7:0]};
endmodule

/* cfq_pkg.sv */
package cfq_pkg;

    // ------------------------------------------------------------
    // queue and bus geometry
    // ------------------------------------------------------------
    localparam int unsigned QUEUE_DEPTH = 4;
    localparam logic [2:0] QUEUE_FULL = 3'h4;
    localparam logic [2:0] QCNT_ZERO = 3'h0;
    localparam logic [1:0] QPTR_STEP = 2'h1;
    localparam logic [2:0] QCNT_STEP = 3'h1;
    localparam logic [15:0] ADDR_STEP = 16'h0001;

    // ------------------------------------------------------------
    // memory map
    // ------------------------------------------------------------
    localparam logic [15:0] REG_SPACE_END = 16'h01FF;
    localparam logic [15:0] SPECIAL_HI_START = 16'h1FFE;
    localparam logic [15:0] SPECIAL_HI_END = 16'h2080;
    localparam logic [15:0] ROM_START = 16'h2000;
    localparam logic [15:0] ROM_END = 16'h5FFF;

    // ------------------------------------------------------------
    // datapath constants and status word bits
    // ------------------------------------------------------------
    localparam logic [15:0] CONST_ZERO = 16'h0000;
    localparam logic [15:0] CONST_ONE = 16'h0001;
    localparam logic [15:0] CONST_TWO = 16'h0002;
    localparam logic [7:0] MASK_SEED = 8'h01;
    localparam logic [5:0] LOOP_ZERO = 6'h00;
    localparam logic [5:0] LOOP_STEP = 6'h01;
    localparam int unsigned PSW_Z = 0;
    localparam int unsigned PSW_N = 1;
    localparam int unsigned PSW_C = 2;
    localparam int unsigned PSW_V = 3;
    localparam int unsigned PSW_W = 8;
    localparam int unsigned SIGN_BIT = 15;
    localparam int unsigned EXT_BIT = 16;

    // ------------------------------------------------------------
    // opcode layout: class in top three bits, function in low three
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OPC_ALU, OPC_JUMP, OPC_CALL, OPC_RET, OPC_SHIFT, OPC_BIT, OPC_LOAD, OPC_NOP
    } cfq_opclass_t;

    typedef enum logic [2:0] {
        FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR, FN_INC, FN_DEC, FN_NEG
    } cfq_alufn_t;

    typedef struct packed {
        logic [15:0] addr;
        logic fetch;
        logic internal;
        logic special;
    } cfq_mem_cmd_t;

    function automatic cfq_opclass_t op_class(input logic [7:0] op);
        return cfq_opclass_t'(op[7:5]);
    endfunction

    function automatic cfq_alufn_t op_fn(input logic [7:0] op);
        return cfq_alufn_t'(op[2:0]);
    endfunction

    function automatic logic op_const_two(input logic [7:0] op);
        return op[3];
    endfunction

endpackage

/* test_cpu_fetch_queue_and_register_arithmetic_unit.sv */
`timescale 1ns/1ps
module test_cpu_fetch_queue_and_register_arithmetic_unit
    import cfq_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic irq_req = 1'b0;
    logic [15:0] irq_vector = 16'h0000;
    logic stc, req, ack, rf_rd, irq_ack, req_d;
    cfq_mem_cmd_t cmd;
    logic [15:0] rdata, rf_rdata, pc, program_status_word, upper, lower, exp;
    logic [8:0] rf_addr;
    logic [7:0] ir;
    logic [5:0] loop;
    logic [15:0] fa [$];
    int failures = 0;
    int n_checks = 0;
    logic [7:0] ops [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0D, 8'h06, 8'h07};
    logic [15:0] imms [8] = '{16'h1234, 16'h0034, 16'h0F0F, 16'h00C3, 16'hFFFF, 16'h0000,
        16'h0000, 16'h0000};

    initial forever #4 mclk = ~mclk;

    cfq_cpu_front_end dut (.mclk, .rst_n, .clk_en, .state_clock_output(stc), .mem_req_q(req),
        .mem_cmd_q(cmd), .mem_ack(ack), .mem_rdata(rdata), .rf_rd_q(rf_rd), .rf_addr_q(rf_addr),
        .rf_rdata, .irq_req, .irq_vector, .irq_ack_q(irq_ack), .instr_reg_q(ir),
        .prog_counter_q(pc), .program_status_word_q(program_status_word), .upper_word_q(upper),
        .lower_word_q(lower), .loop_counter_q(loop));
    cfq_mem_model mem_model (.mclk, .mem_req_q(req), .mem_cmd_q(cmd), .mem_ack(ack),
        .mem_rdata(rdata), .rf_rd_q(rf_rd), .rf_addr_q(rf_addr), .rf_rdata);

    // log the address of every new fetch request
    always @(posedge mclk) begin
        req_d <= req;
        if (req && !req_d && cmd.fetch)
            fa.push_back(cmd.addr);
    end

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        n_checks++;
        if (got !== want) begin
            failures++;
            $display("BAD %0t: got %h want %h", $time, got, want);
        end
    endtask
    function automatic logic [15:0] view(input int sel);
        case (sel)
            0: return upper;
            1: return lower;
            2: return pc;
            3: return {15'h0000, program_status_word[PSW_Z]};
            5: return {15'h0000, irq_ack};
            default: return req ? cmd.addr : 16'hDEAD;
        endcase
    endfunction
    // poll a visible value under a bound; running out ends the run
    task automatic await(input int sel, input logic [15:0] want, input int lim);
        int i;
        for (i = 0; i < lim && view(sel) !== want; i++)
            tick;
        check(view(sel), want);
        if (view(sel) !== want)
            tally_and_finish;
    endtask
    function automatic logic [15:0] alu(input logic [7:0] op, input logic [15:0] a, b);
        logic [15:0] k;
        k = op[3] ? 16'h0002 : 16'h0001;
        case (op[2:0])
            3'h0: return a + b;
            3'h1: return a - b;
            3'h2: return a & b;
            3'h3: return a | b;
            3'h4: return a ^ b;
            3'h5: return a + k;
            3'h6: return a - k;
            default: return 16'h0000 - a;
        endcase
    endfunction
    task automatic put3(input logic [15:0] a, input logic [7:0] op, input logic [15:0] imm);
        mem_model.mem[a] = op;
        mem_model.mem[a + 16'h0001] = imm[7:0];
        mem_model.mem[a + 16'h0002] = imm[15:8];
    endtask
    task automatic load_prog;
        put3(16'h0000, 8'h20, 16'h2000);
        for (int k = 0; k < 8; k++)
            put3(16'h2000 + 16'(3 * k), ops[k], imms[k]);
        mem_model.mem[16'h2018] = 8'hA2;
        mem_model.mem[16'h2019] = 8'hA0;
        put3(16'h201A, 8'hC0, 16'h0040);
        put3(16'h201D, 8'h81, 16'h0004);
        put3(16'h2020, 8'hC0, 16'h3000);
        put3(16'h2023, 8'h40, 16'h2100);
        put3(16'h2026, 8'h20, 16'h2026);
        mem_model.mem[16'h2100] = 8'h60;
        put3(16'h3000, 8'h20, 16'h3000);
    endtask

    task automatic t_reset;
        repeat (20) tick;
        check({12'h000, req, stc, rf_rd, irq_ack}, 16'h0000);
        rst_n = 1'b1;
        await(4, 16'h0000, 6);
        check({13'h0000, cmd.fetch, cmd.internal, cmd.special}, 16'h0005);
    endtask
    task automatic t_jump;
        await(4, 16'h2000, 80);
        check({15'h0000, cmd.internal}, 16'h0001);
        check(fa[1], 16'h0001);
        check(fa[2], 16'h0002);
    endtask
    task automatic t_alu;
        mem_model.wait_cyc = 3;
        exp = 16'h0000;
        for (int k = 0; k < 8; k++) begin
            exp = alu(ops[k], exp, imms[k]);
            await(0, exp, 150);
        end
        mem_model.wait_cyc = 0;
        await(3, 16'h0001, 60);
        await(3, 16'h0000, 60);
    endtask
    task automatic t_load_shift;
        await(0, 16'h40BF, 80);
        await(1, 16'hF000, 80);
        check(upper, 16'h040B);
        check({8'h00, ir}, 16'h0081);
        check({10'h000, loop}, 16'h0000);
        await(0, 16'h0020, 80);
    endtask
    task automatic t_call_ret;
        await(4, 16'h2100, 80);
        await(1, 16'h2026, 40);
        await(4, 16'h2026, 80);
    endtask
    task automatic t_irq_freeze;
        irq_vector = 16'h3000;
        irq_req = 1'b1;
        await(5, 16'h0001, 100);
        irq_req = 1'b0;
        await(4, 16'h3000, 8);
        await(2, 16'h3000, 20);
        exp = pc;
        clk_en = 1'b0;
        repeat (10) tick;
        check(pc, exp);
        clk_en = 1'b1;
    endtask

    initial begin
        #1;
        load_prog;
        t_reset;
        t_jump;
        t_alu;
        t_load_shift;
        t_call_ret;
        t_irq_freeze;
        tally_and_finish;
    end
endmodule
